// [adcts_pkg.sv]
package adcts_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int UNITS = 3;
  localparam int CHANS = 4;
  localparam int RES_W = 10;
  localparam int ADDR_W = 12;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] TRIG_SEL_OFF = 12'h000;
  localparam logic [11:0] CTRL_OFF     = 12'h004;
  localparam logic [11:0] STAT_OFF     = 12'h010;
  localparam logic [11:0] STAT_END     = 12'h01c;
  localparam logic [11:0] DATA_OFF     = 12'h040;
  localparam logic [11:0] DATA_END     = 12'h070;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int TS_FIELD_W    = 2;
  localparam int TS_WIDTH      = 6;
  localparam int CTL_SCAN_BIT  = 0;
  localparam int CTL_CONT_BIT  = 1;
  localparam int CTL_TRIGGER_ENABLE_BIT_BIT  = 2;
  localparam int CTL_START_BIT = 3;
  localparam int CTL_CH_LSB    = 4;
  localparam int ST_FLAG_BIT   = 0;
  localparam int ST_IE_BIT     = 1;
  localparam int ST_BUSY_BIT   = 2;
  localparam logic [5:0] TRIG_SEL_RST = 6'h00;
  localparam logic [9:0] TRIAL_INIT   = 10'h200;
  localparam logic [3:0] TOP_BIT      = 4'h9;

  // ****************************************
  // Trigger source codes
  // ****************************************
  localparam logic [1:0] SRC_PIN_OR_MOTOR = 2'h0;
  localparam logic [1:0] SRC_PIN          = 2'h1;
  localparam logic [1:0] SRC_MOTOR        = 2'h2;
  localparam logic [1:0] SRC_SECOND       = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_TIME_NS   = 200;
  localparam int BIT_CYC       = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {SEQ_IDLE, SEQ_CONV} adcts_seq_t;
  typedef enum logic [2:0] {K_NONE, K_TRIG, K_CTRL, K_STAT, K_DATA} adcts_kind_t;

  typedef struct packed {
    adcts_seq_t  state;
    logic        start;
    logic        scan;
    logic        cont;
    logic        trigger_enable_bit;
    logic [1:0]  chSel;
    logic        flag;
    logic        ie;
    logic [1:0]  chan;
    logic [3:0]  bitIdx;
    logic [7:0]  stepCnt;
    logic [9:0]  sar;
  } adcts_unit_t;

  // ****************************************
  // Functions
  // ****************************************
  function automatic adcts_kind_t adcts_kind(input logic [11:0] a);
    adcts_kind_t k;
    k = K_NONE;
    if (a[1:0] == 2'h0) begin
      if (a == TRIG_SEL_OFF) k = K_TRIG;
      else if (a >= CTRL_OFF && a < STAT_OFF) k = K_CTRL;
      else if (a >= STAT_OFF && a < STAT_END) k = K_STAT;
      else if (a >= DATA_OFF && a < DATA_END) k = K_DATA;
    end
    return k;
  endfunction : adcts_kind

  function automatic logic [1:0] adcts_gate(input logic [1:0] sel, input logic pinFall,
                                            input logic motor, input logic second);
    logic g;
    case (sel)
      SRC_PIN_OR_MOTOR: g = pinFall | motor;
      SRC_PIN:          g = pinFall;
      SRC_MOTOR:        g = motor;
      default:          g = second;
    endcase
    return {1'b0, g};
  endfunction : adcts_gate

  function automatic logic [9:0] adcts_resolve(input logic [9:0] sar, input logic [3:0] k,
                                               input logic cmp);
    logic [9:0] r;
    r = sar;
    if (!cmp) r[k] = 1'b0;
    if (k != 4'h0) r[k - 4'h1] = 1'b1;
    return r;
  endfunction : adcts_resolve

endpackage : adcts_pkg

// [adcts_res_if.sv]
`timescale 1ns/10ps
interface adcts_res_if;
  import adcts_pkg::*;
  logic [UNITS-1:0]            wrEn;
  logic [UNITS-1:0][1:0]       wrChan;
  logic [UNITS-1:0][RES_W-1:0] wrData;
  logic [3:0]                  rdAddr;
  logic [RES_W-1:0]            rdData;
  modport seq (output wrEn, output wrChan, output wrData, output rdAddr, input rdData);
  modport mem (input wrEn, input wrChan, input wrData, input rdAddr, output rdData);
endinterface : adcts_res_if

// [adcts_result_mem.sv]
`timescale 1ns/10ps
module adcts_result_mem (
  // Clock and reset
  input  logic          ref_clk,
  input  logic          reset,
  // Result port
  adcts_res_if.mem      res
);
  import adcts_pkg::*;

  typedef struct packed {
    logic [UNITS*CHANS-1:0][RES_W-1:0] words;
    logic [RES_W-1:0]                  rdData;
  } adcts_mem_t;

  adcts_mem_t memReg;
  adcts_mem_t memNext;

  always_comb begin
    memNext = memReg;
    for (int i = 0; i < UNITS; i++) begin
      if (res.wrEn[i]) memNext.words[i * CHANS + int'(res.wrChan[i])] = res.wrData[i];
    end
    // Read data is registered, so the bus samples it one cycle after the address.
    if (int'(res.rdAddr) < UNITS * CHANS) memNext.rdData = memReg.words[res.rdAddr];
    else memNext.rdData = '0;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) memReg <= '0;
    else memReg <= memNext;
  end

  assign res.rdData = memReg.rdData;

endmodule : adcts_result_mem

// [adcts_trig_gate.sv]
`timescale 1ns/10ps
module adcts_trig_gate (
  // Clock and reset
  input  logic                        ref_clk,
  input  logic                        reset,
  // Source selection
  input  logic [adcts_pkg::TS_WIDTH-1:0] trigSel,
  // Start sources
  input  logic                        externalStartPinN,
  input  logic [adcts_pkg::UNITS-1:0] motorTimerTrig,
  input  logic [adcts_pkg::UNITS-1:0] secondTimerTrig,
  // Start requests
  output logic [adcts_pkg::UNITS-1:0] startReq
);
  import adcts_pkg::*;

  typedef struct packed {
    logic [1:0] pinSync;
    logic       pinPrev;
  } adcts_gate_t;

  adcts_gate_t gateReg;
  adcts_gate_t gateNext;
  logic        pinFall;
  logic [1:0]  g;

  always_comb begin
    gateNext = gateReg;
    gateNext.pinSync = {gateReg.pinSync[0], externalStartPinN};
    gateNext.pinPrev = gateReg.pinSync[1];
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) gateReg <= '1;
    else gateReg <= gateNext;
  end

  // Only the second synchroniser stage and its delayed copy feed the edge detector.
  assign pinFall = gateReg.pinPrev & ~gateReg.pinSync[1];

  always_comb begin
    g = '0;
    for (int i = 0; i < UNITS; i++) begin
      g = adcts_gate(trigSel[i*TS_FIELD_W +: TS_FIELD_W], pinFall,
                     motorTimerTrig[i], secondTimerTrig[i]);
      startReq[i] = g[0];
    end
  end

endmodule : adcts_trig_gate

// [adcts_seq.sv]
// How it works
// - Unit 2 source field in bits 5:4.
// - Unit 1 source field in bits 3:2.
// - Unit 0 source field in bits 1:0.
// - Code 00 takes pin or motor timer.
// - Code 01 takes external pin only.
// - Code 10 takes motor timer only.
// - Code 11 takes second timer only.
// - Bits 7:6 read zero, writes ignored.
// - Ten-bit successive approximation per conversion.
// - Start may be set with new mode.
// - Single mode converts one channel once.
// - Single result goes to its channel register.
// - Completion sets end flag, interrupt if enabled.
// - Start held while converting, then cleared.
// - Clearing start aborts single or cycle scan.
// - Continuous scan begins at lowest channel.
// - Each channel result stored when finished.
// - Continuous scan flags, then restarts group.
// - Continuous repeats until start cleared.
// - Cycle scan converts group once, flags.
// - Cycle scan clears start after last.
// - Pin falling edge sets start bit.
// - Timer request sets start, two cycles sooner than pin.
// - Scan type bit matters only in scan.
`timescale 1ns/10ps
module adcts_seq #(
  parameter int STEP_CYC = adcts_pkg::BIT_CYC
) (
  // Clock and reset
  input  logic                                  ref_clk,
  input  logic                                  reset,
  // APB slave
  input  logic                                  psel,
  input  logic                                  penable,
  input  logic                                  pwrite,
  input  logic [adcts_pkg::ADDR_W-1:0]          paddr,
  input  logic [31:0]                           pwdata,
  output logic [31:0]                           prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // Start sources
  input  logic                                  externalStartPinN,
  input  logic [adcts_pkg::UNITS-1:0]           motorTimerTrig,
  input  logic [adcts_pkg::UNITS-1:0]           secondTimerTrig,
  // Analog front end
  output logic [adcts_pkg::UNITS-1:0][adcts_pkg::RES_W-1:0] sarTrial,
  output logic [adcts_pkg::UNITS-1:0][1:0]      sarChan,
  input  logic [adcts_pkg::UNITS-1:0]           sarCompare,
  // Conversion end requests
  output logic [adcts_pkg::UNITS-1:0]           convEndIrq
);
  import adcts_pkg::*;

  // ****************************************
  // Elaboration check
  // ****************************************
  if (STEP_CYC < 1 || STEP_CYC > 255) begin : g_bad_step
    $error("STEP_CYC must lie between 1 and 255");
  end

  // Each bit step lasts STEP_CYC cycles; the comparator is read only in the last one.
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);

  typedef struct packed {
    logic [TS_WIDTH-1:0]      trigSel;
    logic [31:0]              rdata;
    adcts_unit_t [UNITS-1:0]  units;
  } adcts_top_t;

  adcts_top_t         topReg;
  adcts_top_t         topNext;
  adcts_res_if        res ();
  adcts_kind_t        kind;
  logic               accWr;
  logic [UNITS-1:0]   startReq;
  logic [UNITS-1:0]   doneEvt;
  logic [UNITS-1:0]   ctrlWr;
  logic [UNITS-1:0]   statWr;
  logic [11:0]        dataIdx;
  adcts_unit_t        u;

  // ****************************************
  // Submodules
  // ****************************************
  adcts_trig_gate u_gate (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .trigSel           (topReg.trigSel),
    .externalStartPinN (externalStartPinN),
    .motorTimerTrig    (motorTimerTrig),
    .secondTimerTrig   (secondTimerTrig),
    .startReq          (startReq)
  );

  adcts_result_mem u_mem (
    .ref_clk (ref_clk),
    .reset   (reset),
    .res     (res.mem)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  assign kind    = adcts_kind(paddr);
  assign accWr   = psel & penable & pwrite;
  // Zero wait states, so every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (kind == K_NONE);
  assign dataIdx = (paddr - DATA_OFF) >> 2;
  assign res.rdAddr = dataIdx[3:0];
  assign prdata  = (kind == K_DATA) ? {22'h000000, res.rdData} : topReg.rdata;

  always_comb begin
    for (int i = 0; i < UNITS; i++) begin
      ctrlWr[i] = accWr && (kind == K_CTRL) && (paddr == CTRL_OFF + 12'(4 * i));
      statWr[i] = accWr && (kind == K_STAT) && (paddr == STAT_OFF + 12'(4 * i));
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    topNext = topReg;
    doneEvt = '0;
    u = topReg.units[0];
    if (accWr && kind == K_TRIG) begin
      // Bits 7:6 are not stored, so they always read back as zero.
      topNext.trigSel = pwdata[TS_WIDTH-1:0];
    end
    for (int i = 0; i < UNITS; i++) begin
      u = topReg.units[i];
      res.wrEn[i]   = 1'b0;
      res.wrChan[i] = u.chan;
      res.wrData[i] = adcts_resolve(u.sar, 4'h0, sarCompare[i]);
      if (statWr[i]) begin
        u.ie = pwdata[ST_IE_BIT];
        if (!pwdata[ST_FLAG_BIT]) u.flag = 1'b0;
      end
      if (u.state == SEQ_CONV) begin
        if (u.stepCnt == STEP_LAST) begin
          u.stepCnt = 8'h00;
          u.sar = adcts_resolve(u.sar, u.bitIdx, sarCompare[i]);
          if (u.bitIdx == 4'h0) begin
            res.wrEn[i] = 1'b1;
            if (!u.scan || u.chan == u.chSel) begin
              doneEvt[i] = 1'b1;
              u.flag = 1'b1;
              u.chan = u.scan ? 2'h0 : u.chSel;
              if (u.scan && u.cont) begin
                u.bitIdx = TOP_BIT;
                u.sar = TRIAL_INIT;
              end else begin
                u.start = 1'b0;
                u.state = SEQ_IDLE;
              end
            end else begin
              u.chan = u.chan + 2'h1;
              u.bitIdx = TOP_BIT;
              u.sar = TRIAL_INIT;
            end
          end else begin
            u.bitIdx = u.bitIdx - 4'h1;
          end
        end else begin
          u.stepCnt = u.stepCnt + 8'h01;
        end
      end
      // The control write follows the conversion step, so a clear of start leaves the unit idle unless an enabled trigger request arrives in the same cycle.
      if (ctrlWr[i]) begin
        u.scan  = pwdata[CTL_SCAN_BIT];
        u.cont  = pwdata[CTL_CONT_BIT];
        u.trigger_enable_bit  = pwdata[CTL_TRIGGER_ENABLE_BIT_BIT];
        u.chSel = pwdata[CTL_CH_LSB +: 2];
        u.start = pwdata[CTL_START_BIT];
        if (!pwdata[CTL_START_BIT]) u.state = SEQ_IDLE;
      end
      if (u.trigger_enable_bit && startReq[i]) u.start = 1'b1;
      if (u.start && u.state == SEQ_IDLE) begin
        // A trigger start and a software start take this same path.
        u.state   = SEQ_CONV;
        u.chan    = u.scan ? 2'h0 : u.chSel;
        u.bitIdx  = TOP_BIT;
        u.sar     = TRIAL_INIT;
        u.stepCnt = 8'h00;
      end
      topNext.units[i] = u;
    end
    if (psel && !penable) begin
      topNext.rdata = 32'h00000000;
      case (kind)
        K_TRIG: topNext.rdata = {26'h0000000, topReg.trigSel};
        K_CTRL: begin
          for (int i = 0; i < UNITS; i++) begin
            if (paddr == CTRL_OFF + 12'(4 * i)) begin
              topNext.rdata = {26'h0000000, topReg.units[i].chSel, topReg.units[i].start,
                               topReg.units[i].trigger_enable_bit, topReg.units[i].cont,
                               topReg.units[i].scan};
            end
          end
        end
        K_STAT: begin
          for (int i = 0; i < UNITS; i++) begin
            if (paddr == STAT_OFF + 12'(4 * i)) begin
              topNext.rdata = {29'h00000000, topReg.units[i].state == SEQ_CONV,
                               topReg.units[i].ie, topReg.units[i].flag};
            end
          end
        end
        default: topNext.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) topReg <= '0;
    else topReg <= topNext;
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    for (int i = 0; i < UNITS; i++) begin
      sarTrial[i]   = topReg.units[i].sar;
      sarChan[i]    = topReg.units[i].chan;
      convEndIrq[i] = topReg.units[i].flag & topReg.units[i].ie;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence unit0Done;
    doneEvt[0] && !ctrlWr[0] && !startReq[0];
  endsequence

  sequence unit0Launch;
    topReg.units[0].state == SEQ_IDLE && topReg.units[0].trigger_enable_bit && startReq[0] && !ctrlWr[0];
  endsequence

  sequence unit0LastStep;
    topReg.units[0].state == SEQ_CONV && topReg.units[0].stepCnt == STEP_LAST;
  endsequence

  trig_sel_store_a: assert property (accWr && kind == K_TRIG |=>
    topReg.trigSel == $past(pwdata[5:0]))
    else $error("trigger select not stored");

  rsvd_zero_a: assert property (psel && penable && kind == K_TRIG |->
    prdata[31:6] == 26'h0000000)
    else $error("reserved trigger bits not zero");

  src_motor_only_a: assert property (topReg.trigSel[1:0] == SRC_MOTOR && !motorTimerTrig[0]
    |-> !startReq[0])
    else $error("unit0 started without motor trigger");

  src_second_a: assert property (topReg.trigSel[1:0] == SRC_SECOND && secondTimerTrig[0]
    |-> startReq[0])
    else $error("unit0 second timer trigger lost");

  src_both_a: assert property (topReg.trigSel[1:0] == SRC_PIN_OR_MOTOR && motorTimerTrig[0]
    |-> startReq[0])
    else $error("unit0 motor trigger lost under code 00");

  trig_launch_a: assert property (unit0Launch |=>
    topReg.units[0].state == SEQ_CONV && topReg.units[0].start && topReg.units[0].stepCnt == 8'h00)
    else $error("trigger did not launch conversion");

  single_end_a: assert property (unit0Done ##0 !topReg.units[0].scan |=>
    !topReg.units[0].start && topReg.units[0].state == SEQ_IDLE && topReg.units[0].flag)
    else $error("single conversion did not finish cleanly");

  cont_restart_a: assert property (unit0Done ##0 topReg.units[0].scan && topReg.units[0].cont
    |=> topReg.units[0].state == SEQ_CONV && topReg.units[0].chan == 2'h0
        && topReg.units[0].bitIdx == TOP_BIT)
    else $error("continuous scan did not restart");

  abort_idle_a: assert property (ctrlWr[0] && !pwdata[CTL_START_BIT] && !startReq[0] |=>
    topReg.units[0].state == SEQ_IDLE && !topReg.units[0].start)
    else $error("clearing start did not abort");

  result_store_a: assert property (topReg.units[0].state == SEQ_CONV
    && topReg.units[0].bitIdx == 4'h0 && topReg.units[0].stepCnt == STEP_LAST
    |-> res.wrEn[0] && res.wrChan[0] == topReg.units[0].chan)
    else $error("finished channel result not written");

  irq_on_done_a: assert property (doneEvt[0] && (topReg.units[0].ie && !statWr[0]) |=>
    convEndIrq[0])
    else $error("end interrupt not raised");

  src_pin_only_a: assert property (topReg.trigSel[3:2] == SRC_PIN |->
    startReq[1] == u_gate.pinFall)
    else $error("unit1 pin-only gating wrong");

  pin_start_a: assert property (u_gate.pinFall && topReg.trigSel[1] == 1'b0
    && topReg.units[0].trigger_enable_bit && !ctrlWr[0] |=> topReg.units[0].start)
    else $error("pin edge did not set start");

  single_chan_a: assert property (unit0Done ##0 !topReg.units[0].scan |->
    res.wrChan[0] == topReg.units[0].chSel)
    else $error("single result sent to wrong channel");

  scan_launch_a: assert property (ctrlWr[0] && pwdata[CTL_START_BIT]
    && pwdata[CTL_SCAN_BIT] && topReg.units[0].state == SEQ_IDLE
    |=> topReg.units[0].state == SEQ_CONV && topReg.units[0].chan == 2'h0)
    else $error("scan did not begin at first channel");

  scan_step_a: assert property (unit0LastStep ##0 topReg.units[0].bitIdx == 4'h0
    && topReg.units[0].scan && topReg.units[0].chan != topReg.units[0].chSel && !ctrlWr[0]
    |=> topReg.units[0].chan == $past(topReg.units[0].chan) + 2'h1)
    else $error("scan skipped a channel");

  // Unit 2 is the one that runs a single-cycle scan, so its end is watched here.
  cycle_end_a: assert property (doneEvt[2] && !ctrlWr[2] && !startReq[2]
    && topReg.units[2].scan && !topReg.units[2].cont |=> topReg.units[2].state == SEQ_IDLE
        && !topReg.units[2].start && topReg.units[2].flag)
    else $error("cycle scan did not stop");

  irq_off_a: assert property (statWr[0] && !pwdata[ST_IE_BIT] |=> !convEndIrq[0])
    else $error("end interrupt not withdrawn");

  start_held_a: assert property (topReg.units[0].state == SEQ_CONV |->
    topReg.units[0].start)
    else $error("start dropped while converting");

  // The hardware set must beat a software clear in the same cycle, or an end is lost.
  flag_set_a: assert property (doneEvt[0] |=> topReg.units[0].flag)
    else $error("end flag not set");

  idle_no_write_a: assert property (topReg.units[0].state == SEQ_IDLE |->
    !res.wrEn[0])
    else $error("result written while idle");

endmodule : adcts_seq

// [adcts_analog_model.sv]
`timescale 1ns/10ps
module adcts_analog_model (
  // Converter side
  input  wire logic [2:0][9:0]      sarTrial,
  input  wire logic [2:0][1:0]      sarChan,
  output logic      [2:0]           sarCompare,
  // Input levels per unit and channel
  input  wire logic [2:0][3:0][9:0] level
);
  // ****************************************
  // Comparator
  // ****************************************
  // An ideal comparator, so a correct ten-step search returns the level itself.
  always_comb begin
    for (int u = 0; u < 3; u++) begin
      sarCompare[u] = (level[u][sarChan[u]] >= sarTrial[u]);
    end
  end
endmodule : adcts_analog_model

// [adc_trigger_and_scan_sequencer_tb_top.sv]
`timescale 1ns/10ps
module adc_trigger_and_scan_sequencer_tb_top;
  import adcts_pkg::*;
  logic                        ref_clk = 1'b0;
  logic                        reset   = 1'b1;
  logic                        psel    = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite  = 1'b0;
  logic [ADDR_W-1:0]           paddr   = '0;
  logic [31:0]                 pwdata  = '0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        pinN    = 1'b1;
  logic [UNITS-1:0]            motor   = '0;
  logic [UNITS-1:0]            second  = '0;
  logic [UNITS-1:0][RES_W-1:0] sarTrial;
  logic [UNITS-1:0][1:0]       sarChan;
  logic [UNITS-1:0]            sarCompare;
  logic [UNITS-1:0]            convEndIrq;
  logic [2:0][3:0][9:0]        level;
  logic [31:0]                 rd;
  logic                        err;
  int                          error_cnt   = 0;
  int                          checks_done = 0;
  int                          u;
  // Bit s of each row: motor timer, second timer, pin; rows by source code.
  logic [3:0][2:0]             trigExp = {3'b010, 3'b001, 3'b100, 3'b101};

  always #10 ref_clk = ~ref_clk;

  adcts_seq #(.STEP_CYC(1)) adcts_seq_inst (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .externalStartPinN(pinN), .motorTimerTrig(motor), .secondTimerTrig(second),
    .sarTrial(sarTrial), .sarChan(sarChan), .sarCompare(sarCompare),
    .convEndIrq(convEndIrq));

  adcts_analog_model adcts_analog_model_inst (
    .sarTrial(sarTrial), .sarChan(sarChan), .sarCompare(sarCompare), .level(level));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [9:0] lv(input int un, input int c);
    return 10'(un * 273 + c * 77 + 35);
  endfunction : lv

  function automatic logic [11:0] ctl(input int un);
    return CTRL_OFF + 12'(4 * un);
  endfunction : ctl

  function automatic logic [11:0] stat(input int un);
    return STAT_OFF + 12'(4 * un);
  endfunction : stat

  function automatic logic [11:0] dat(input int un, input int c);
    return DATA_OFF + 12'(16 * un + 4 * c);
  endfunction : dat

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One transfer; entered just after a rising edge, leaves one idle cycle behind it.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 50) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wait_bit(input logic [11:0] a, input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while (rd[b] !== v && n < 200) begin
      n++;
      apb(1'b0, a, 32'h0);
    end
    check("poll", 32'(rd[b]), 32'(v));
  endtask : wait_bit

  task automatic fire(input int un, input int s);
    if (s == 2) pinN <= 1'b0;
    else if (s == 1) second[un] <= 1'b1;
    else motor[un] <= 1'b1;
    @(posedge ref_clk);
    pinN <= 1'b1;
    second <= '0;
    motor <= '0;
  endtask : fire

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    for (int i = 0; i < 3; i++) for (int c = 0; c < 4; c++) level[i][c] = lv(i, c);
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, TRIG_SEL_OFF, 32'h0);
    check("trigsel reset", rd, 32'h0);
    apb(1'b1, TRIG_SEL_OFF, 32'h000000ff);
    apb(1'b0, TRIG_SEL_OFF, 32'h0);
    check("trigsel reserved", rd, 32'h0000003f);
    apb(1'b1, TRIG_SEL_OFF, 32'h0000001b);
    apb(1'b0, TRIG_SEL_OFF, 32'h0);
    check("trigsel fields", rd, 32'h0000001b);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    apb(1'b1, TRIG_SEL_OFF, 32'h0);
    $display("test registers done");
    apb(1'b1, ctl(0), 32'h0000002a);
    apb(1'b0, ctl(0), 32'h0);
    check("single start held", 32'(rd[CTL_START_BIT]), 32'h1);
    wait_bit(stat(0), ST_BUSY_BIT, 1'b0);
    apb(1'b0, dat(0, 2), 32'h0);
    check("single result", rd, 32'(lv(0, 2)));
    apb(1'b0, dat(0, 1), 32'h0);
    check("single other chan", rd, 32'h0);
    apb(1'b0, stat(0), 32'h0);
    check("single flag", 32'(rd[ST_FLAG_BIT]), 32'h1);
    apb(1'b0, ctl(0), 32'h0);
    check("single start clear", 32'(rd[CTL_START_BIT]), 32'h0);
    check("irq masked", 32'(convEndIrq[0]), 32'h0);
    apb(1'b1, stat(0), 32'h00000003);
    check("irq raised", 32'(convEndIrq[0]), 32'h1);
    apb(1'b1, stat(0), 32'h00000002);
    check("irq cleared", 32'(convEndIrq[0]), 32'h0);
    apb(1'b1, stat(0), 32'h0);
    $display("test single done");
    apb(1'b1, ctl(1), 32'h00000038);
    apb(1'b1, ctl(1), 32'h0);
    apb(1'b0, stat(1), 32'h0);
    check("abort status", rd, 32'h0);
    apb(1'b0, dat(1, 3), 32'h0);
    check("abort no result", rd, 32'h0);
    $display("test abort done");
    apb(1'b1, ctl(2), 32'h00000039);
    check("scan first chan", 32'(sarChan[2]), 32'h0);
    wait_bit(stat(2), ST_BUSY_BIT, 1'b0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, dat(2, c), 32'h0);
      check("cycle result", rd, 32'(lv(2, c)));
    end
    apb(1'b0, stat(2), 32'h0);
    check("cycle flag", 32'(rd[ST_FLAG_BIT]), 32'h1);
    apb(1'b0, ctl(2), 32'h0);
    check("cycle start clear", 32'(rd[CTL_START_BIT]), 32'h0);
    check("cycle final trial", 32'(sarTrial[2]), 32'(lv(2, 3)));
    $display("test cycle scan done");
    apb(1'b1, ctl(0), 32'h0000001b);
    wait_bit(stat(0), ST_FLAG_BIT, 1'b1);
    level[0][0] <= 10'h3a5;
    level[0][1] <= 10'h05a;
    // Two full passes so that both channels hold the new levels.
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, stat(0), 32'h2);
      wait_bit(stat(0), ST_FLAG_BIT, 1'b1);
    end
    check("cont irq", 32'(convEndIrq[0]), 32'h1);
    apb(1'b0, dat(0, 0), 32'h0);
    check("cont chan0", rd, 32'h000003a5);
    apb(1'b0, dat(0, 1), 32'h0);
    check("cont chan1", rd, 32'h0000005a);
    apb(1'b0, ctl(0), 32'h0);
    check("cont start held", 32'(rd[CTL_START_BIT]), 32'h1);
    apb(1'b1, ctl(0), 32'h00000003);
    apb(1'b0, stat(0), 32'h0);
    check("cont stopped", 32'(rd[ST_BUSY_BIT]), 32'h0);
    $display("test continuous done");
    for (int code = 0; code < 4; code++) begin
      u = code % 3;
      for (int s = 0; s < 3; s++) begin
        apb(1'b1, ctl(u), 32'h0);
        apb(1'b1, TRIG_SEL_OFF, 32'(code) << (2 * u));
        apb(1'b1, stat(u), 32'h0);
        apb(1'b1, ctl(u), 32'h00000004);
        fire(u, s);
        repeat (4) @(posedge ref_clk);
        apb(1'b0, stat(u), 32'h0);
        check("trig start", 32'(rd[ST_BUSY_BIT]), 32'(trigExp[code][s]));
        wait_bit(stat(u), ST_BUSY_BIT, 1'b0);
      end
    end
    $display("test triggers done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
endmodule : adc_trigger_and_scan_sequencer_tb_top
